// ### pvi_capture.sv
//------------------------------------------------------------------------------
// Purpose: capture of the parallel pixel word on the selected pixel clock
//          edge, control filtering and reduced colour general-purpose pins
// Assumes: pixel clock well below a quarter of clk_in; pins asynchronous
// Notes:   output follows the pixel clock edge by four clk_in cycles
//------------------------------------------------------------------------------
// How it works
// - accept a 31-bit parallel word per pixel
// - forward 24 colour bits, three controls, audio
// - strobe edge picked by a configuration bit
// - filter on: drop sync/valid pulses under three
// - filter off: pass sync/valid with no minimum
// - low red/green bits become GPIO 0..3
// - low blue bits become register outputs 4,5
// - these pins exist only in 18-bit mode
// - power-down low holds control registers reset
`timescale 1ns/10ps

module pvi_capture import pvi_pkg::*; (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // pixel pins
    input  wire logic                 pclk_in,
    input  wire pvi_word_t            word_in,
    // device pins
    input  wire logic                 power_down_n_in,
    input  wire logic                 mode_sel_in,
    // configuration
    input  wire logic                 strobe_edge_select_in,
    input  wire logic                 filter_enable_in,
    input  wire logic                 cfg_18bit_in,
    input  wire logic [GPIO_N-1:0]    gpio_dir_in,
    input  wire logic [GPIO_N-1:0]    gpio_value_in,
    input  wire logic [REG_OUT_N-1:0] register_driven_output_in,
    // captured pixel
    output pvi_word_t                 pixel_out,
    output logic                      pixel_strobe_out,
    // general-purpose pins
    output logic [GPIO_N-1:0]         gpio_out,
    output logic [GPIO_N-1:0]         gpio_oe_n_out,
    output logic [GPIO_N-1:0]         gpio_read_out,
    output logic [REG_OUT_N-1:0]      reg_pin_out,
    output logic [REG_OUT_N-1:0]      reg_pin_oe_n_out,
    // status
    output logic                      mode_18bit_out
);
    logic                 pclk_s1, pclk_s2, pclk_s3;
    logic                 pd_s1, pd_s2, msel_s1, msel_s2;
    pvi_word_t            word_s1, word_s2, cap;
    logic                 rst;
    logic                 strobe, strobe_d, strobe_d2;
    logic                 edge_rise, filt_en, m18;
    logic [GPIO_N-1:0]    dir_q, val_q;
    logic [REG_OUT_N-1:0] reg_q;
    logic [1:0]           filt_out;

    //------------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------------
    // all pin inputs take two flops; pclk gets a third for edge finding
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pclk_s1 <= 1'b0;
            pclk_s2 <= 1'b0;
            pclk_s3 <= 1'b0;
            pd_s1   <= 1'b0;
            pd_s2   <= 1'b0;
            msel_s1 <= 1'b0;
            msel_s2 <= 1'b0;
            word_s1 <= '0;
            word_s2 <= '0;
        end else begin
            pclk_s1 <= pclk_in;
            pclk_s2 <= pclk_s1;
            pclk_s3 <= pclk_s2;
            pd_s1   <= power_down_n_in;
            pd_s2   <= pd_s1;
            msel_s1 <= mode_sel_in;
            msel_s2 <= msel_s1;
            word_s1 <= word_in;
            word_s2 <= word_s1;
        end
    end

    // powered down acts as reset for everything past the synchronisers
    assign rst = !rst_n_in || !pd_s2;

    //------------------------------------------------------------------------
    // control registers
    //------------------------------------------------------------------------
    // held clear while powered down, so a wake-up starts from defaults
    always_ff @(posedge clk_in) begin
        if (rst) begin
            edge_rise <= RST_CTRL_BIT;
            filt_en   <= RST_CTRL_BIT;
            m18       <= RST_CTRL_BIT;
            dir_q     <= '0;
            val_q     <= '0;
            reg_q     <= '0;
        end else begin
            edge_rise <= strobe_edge_select_in == EDGE_RISE;
            filt_en   <= filter_enable_in;
            m18       <= msel_s2 || cfg_18bit_in;
            dir_q     <= gpio_dir_in;
            val_q     <= gpio_value_in;
            reg_q     <= register_driven_output_in;
        end
    end

    //------------------------------------------------------------------------
    // strobe and capture
    //------------------------------------------------------------------------
    // edge found on synchronised copies, so data and clock share latency
    assign strobe = edge_rise ? (pclk_s2 && !pclk_s3)
                              : (!pclk_s2 && pclk_s3);

    // single capture stage ahead of the filter
    always_ff @(posedge clk_in) begin
        if (rst) begin
            cap       <= '0;
            strobe_d  <= 1'b0;
            strobe_d2 <= 1'b0;
        end else begin
            strobe_d  <= strobe;
            strobe_d2 <= strobe_d;
            if (strobe) begin
                cap <= word_s2;
            end
        end
    end

    pvi_filter #(
        .WIDTH     (CTRL_FILT_N),
        .MIN_PULSE (MIN_PULSE_PCLK)
    ) u_filter (
        .clk_in    (clk_in),
        .rst_in    (rst),
        .step_in   (strobe_d),
        .enable_in (filt_en),
        .level_in  ({cap.pixel_valid, cap.line_sync}),
        .level_out (filt_out)
    );

    //------------------------------------------------------------------------
    // forwarded pixel
    //------------------------------------------------------------------------
    // sync/valid carry the filter delay; colour does not, a known skew
    always_ff @(posedge clk_in) begin
        if (rst) begin
            pixel_out        <= '0;
            pixel_strobe_out <= 1'b0;
        end else begin
            pixel_strobe_out <= strobe_d2;
            if (strobe_d2) begin
                pixel_out             <= cap;
                pixel_out.line_sync   <= filt_out[FILT_LINE];
                pixel_out.pixel_valid <= filt_out[FILT_VALID];
                if (m18) begin
                    pixel_out.red[1:0]   <= 2'h0;
                    pixel_out.green[1:0] <= 2'h0;
                    pixel_out.blue[1:0]  <= 2'h0;
                end
            end
        end
    end

    //------------------------------------------------------------------------
    // general-purpose pins
    //------------------------------------------------------------------------
    // pins stay undriven unless 18-bit mode frees the colour bits
    always_ff @(posedge clk_in) begin
        if (rst) begin
            gpio_out         <= '0;
            gpio_oe_n_out    <= RST_GPIO_OE_N;
            gpio_read_out    <= '0;
            reg_pin_out      <= '0;
            reg_pin_oe_n_out <= '1;
            mode_18bit_out   <= 1'b0;
        end else begin
            mode_18bit_out <= m18;
            gpio_out       <= val_q;
            gpio_oe_n_out  <= m18 ? ~dir_q : RST_GPIO_OE_N;
            gpio_read_out  <= m18 ? {word_s2.green[1:0], word_s2.red[1:0]}
                                  : '0;
            reg_pin_out      <= m18 ? reg_q : '0;
            reg_pin_oe_n_out <= m18 ? '0 : '1;
        end
    end

    //------------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------------
    sequence s_strobe_seen;
        strobe ##1 strobe_d;
    endsequence

    property p_word_width;
        @(posedge clk_in) disable iff (rst)
        s_strobe_seen ##3 1'b1 |-> $bits(pixel_out) == WORD_W
            && pixel_out.aud_data == cap.aud_data;
    endproperty
    a_word_width: assert property (p_word_width)
        else $error("audio lines not forwarded with the pixel");

    property p_colour_forward;
        @(posedge clk_in) disable iff (rst)
        s_strobe_seen |-> ##3 pixel_out.green[7:2] == cap.green[7:2]
            && pixel_out.frame_sync == cap.frame_sync;
    endproperty
    a_colour_forward: assert property (p_colour_forward)
        else $error("colour or frame sync not forwarded");

    property p_edge_select;
        @(posedge clk_in) disable iff (rst)
        strobe |-> $past(pclk_s1) == edge_rise && $past(pclk_s2) != edge_rise;
    endproperty
    a_edge_select: assert property (p_edge_select)
        else $error("strobe on the wrong pixel clock edge");

    property p_capture_stage;
        @(posedge clk_in) disable iff (rst)
        strobe |=> cap == $past(word_s2);
    endproperty
    a_capture_stage: assert property (p_capture_stage)
        else $error("capture stage missed the strobe");

    property p_gpio_gated;
        @(posedge clk_in) disable iff (rst)
        !m18 |=> gpio_oe_n_out == RST_GPIO_OE_N;
    endproperty
    a_gpio_gated: assert property (p_gpio_gated)
        else $error("gpio driven outside 18-bit mode");

    property p_reg_out;
        @(posedge clk_in) disable iff (rst)
        m18 |=> reg_pin_out == $past(reg_q) && reg_pin_oe_n_out == '0;
    endproperty
    a_reg_out: assert property (p_reg_out)
        else $error("register outputs not driven in 18-bit mode");

    property p_low_bits_cleared;
        @(posedge clk_in) disable iff (rst)
        (s_strobe_seen ##1 m18) |=> pixel_out.blue[1:0] == 2'h0
            && pixel_out.red[1:0] == 2'h0;
    endproperty
    a_low_bits_cleared: assert property (p_low_bits_cleared)
        else $error("colour low bits leaked in 18-bit mode");

    property p_power_down;
        @(posedge clk_in) disable iff (!rst_n_in)
        !pd_s2 |=> !m18 && !filt_en && !pixel_strobe_out;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("control state not cleared in power down");
endmodule

// ### pvi_filter.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and word layout for the parallel video input,
//          plus the pulse-width filter for line sync and pixel valid
// Assumes: filter steps once per captured pixel, on a one-cycle step pulse
// Notes:   vertical sync is never filtered; it is slow by contract
//------------------------------------------------------------------------------
`timescale 1ns/10ps

package pvi_pkg;
    localparam int        COLOUR_W        = 8;
    localparam int        WORD_W          = 31;
    localparam int        GPIO_N          = 4;
    localparam int        REG_OUT_N       = 2;
    localparam int        CTRL_FILT_N     = 2;
    localparam int        MIN_PULSE_PCLK  = 3;
    localparam int        SRC_WINDOW_PCLK = 130;
    localparam int        CLK_PERIOD_NS   = 40;
    localparam int        PIPE_TO_OUT     = 4;
    localparam logic      EDGE_RISE       = 1'b1;
    localparam logic      RST_CTRL_BIT    = 1'b0;
    localparam logic [3:0] RST_GPIO_OE_N  = 4'hf;
    // bit positions of control lines in the filtered pair
    localparam int        FILT_LINE       = 0;
    localparam int        FILT_VALID      = 1;

    // the 31-bit parallel word as it arrives on the pins
    typedef struct packed {
        logic [COLOUR_W-1:0] red;
        logic [COLOUR_W-1:0] green;
        logic [COLOUR_W-1:0] blue;
        logic                line_sync;
        logic                frame_sync;
        logic                pixel_valid;
        logic                aud_clk;
        logic                aud_word;
        logic [1:0]          aud_data;
    } pvi_word_t;
endpackage

module pvi_filter import pvi_pkg::*; #(
    parameter int WIDTH     = CTRL_FILT_N,
    parameter int MIN_PULSE = MIN_PULSE_PCLK
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             step_in,
    input  wire logic             enable_in,
    // levels
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [1:0] held [WIDTH];

    //------------------------------------------------------------------------
    // one filter per control line
    //------------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_line
        // new level must persist MIN_PULSE samples; delay keeps width intact
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                level_out[i] <= RST_CTRL_BIT;
                held[i]      <= 2'h0;
            end else if (step_in) begin
                if (!enable_in) begin
                    level_out[i] <= level_in[i];
                    held[i]      <= 2'h0;
                end else if (level_in[i] == level_out[i]) begin
                    held[i] <= 2'h0;              // short pulse dropped
                end else if (held[i] == 2'(MIN_PULSE - 1)) begin
                    level_out[i] <= level_in[i];
                    held[i]      <= 2'h0;
                end else begin
                    held[i] <= held[i] + 2'h1;
                end
            end
        end

        property p_filter_min_width;
            @(posedge clk_in) disable iff (rst_in)
            ($past(enable_in) && $past(step_in) && $changed(level_out[i]))
                |-> $past(held[i]) == 2'(MIN_PULSE - 1);
        endproperty
        a_filter_min_width: assert property (p_filter_min_width)
            else $error("filtered control changed before minimum width");

        property p_filter_bypass;
            @(posedge clk_in) disable iff (rst_in)
            (step_in && !enable_in) |=> level_out[i] == $past(level_in[i]);
        endproperty
        a_filter_bypass: assert property (p_filter_bypass)
            else $error("unfiltered control did not pass straight through");
    end
endmodule

// ### pvi_src_model.sv
// Purpose: source model, pixel clock and parallel word pins
// Assumes: word changes on the edge the device does not sample
// Notes:   clock stands still while run_in is low
`timescale 1ns/10ps

module pvi_src_model import pvi_pkg::*; (
    // control
    input  wire logic      run_in,
    input  wire logic      rise_in,
    input  wire pvi_word_t word_next_in,
    // pins
    output logic           pclk_out,
    output pvi_word_t      word_out
);
    // ------
    // pixel clock
    // ------
    // 320 ns period; start offset keeps edges away from clk_in edges
    initial begin
        pclk_out = 1'b0;
        word_out = '0;
        forever begin
            if (run_in) begin
                #160;
                pclk_out = ~pclk_out;
            end else begin
                @(run_in);
                #13;
            end
        end
    end

    // launch on the opposite edge so pins are quiet around the strobe
    always @(pclk_out) begin
        // only while running, so the time-zero level change launches nothing
        if (run_in === 1'b1 && pclk_out !== rise_in) begin
            word_out <= word_next_in;
        end
    end
endmodule

// ### tb_pvi_capture.sv
// Purpose: self-checking bench for the parallel video capture
// Assumes: config changes only while the pixel clock stands still
// Notes:   expected words are queued at each strobe edge of the pins
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end

module tb_pvi_capture import pvi_pkg::*; ;
    logic                 clk_in, rst_n_in, pd_n, msel, sel, fe, cfg18, run;
    logic                 pclk, strobe, m18, ls, fs, pv, m;
    logic [GPIO_N-1:0]    dir, val, g_out, g_oe_n, g_rd;
    logic [REG_OUT_N-1:0] rdo, r_out, r_oe_n;
    logic [1:0]           h1, h2, fl, s;
    pvi_word_t            nxt, src, pins, pix, e, q;
    pvi_word_t            expq[$];
    int                   fails, n_compared, seed;

    // ------
    // parts
    // ------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // shared pins: device drives them where its enable is low
    always_comb begin
        pins = src;
        for (int i = 0; i < 2; i++) begin
            if (!g_oe_n[i]) pins.red[i] = g_out[i];
            if (!g_oe_n[i+2]) pins.green[i] = g_out[i+2];
            if (!r_oe_n[i]) pins.blue[i] = r_out[i];
        end
    end

    pvi_src_model SRC (.run_in(run), .rise_in(sel), .word_next_in(nxt),
        .pclk_out(pclk), .word_out(src));

    pvi_capture DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .pclk_in(pclk),
        .word_in(pins), .power_down_n_in(pd_n), .mode_sel_in(msel),
        .strobe_edge_select_in(sel), .filter_enable_in(fe),
        .cfg_18bit_in(cfg18), .gpio_dir_in(dir), .gpio_value_in(val),
        .register_driven_output_in(rdo), .pixel_out(pix),
        .pixel_strobe_out(strobe), .gpio_out(g_out), .gpio_oe_n_out(g_oe_n),
        .gpio_read_out(g_rd), .reg_pin_out(r_out), .reg_pin_oe_n_out(r_oe_n),
        .mode_18bit_out(m18));

    // ------
    // expectation and checking
    // ------
    // 18-bit mode hands the low colour bits to the pins, so they read as zero
    function automatic pvi_word_t low_cleared(input pvi_word_t w, input logic m);
        pvi_word_t r;
        r = w;
        if (m) begin
            r.red[1:0]   = 2'h0;
            r.green[1:0] = 2'h0;
            r.blue[1:0]  = 2'h0;
        end
        return r;
    endfunction

    // filter modelled as three matching pixels in a row on the captured levels
    always @(pclk) begin
        if (pclk === sel && rst_n_in && pd_n) begin
            e = pins;
            s = {pins.pixel_valid, pins.line_sync};
            if (!fe || (s == h1 && h1 == h2)) fl = s;
            h2 = h1;
            h1 = s;
            e.line_sync = fl[FILT_LINE];
            e.pixel_valid = fl[FILT_VALID];
            expq.push_back(low_cleared(e, msel || cfg18));
        end
    end

    // a strobe with nothing queued is an extra pixel
    always @(posedge clk_in) begin
        if (strobe === 1'b1) begin
            q = (expq.size() > 0) ? expq.pop_front() : ~pix;
            `CHK(pix, q)
        end
    end

    // ------
    // stimulus
    // ------
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    // one frame toggle, an l-pixel sync/valid pulse, then quiet pixels
    task automatic burst(input int l);
        run = 1'b1;
        for (int i = 0; i < 134; i++) begin
            do @(pclk); while (pclk === sel);
            #1;
            nxt = pvi_word_t'(WORD_W'($random(seed)));
            if (i == 0) fs = ~fs;
            ls = (i < l);
            pv = ls;
            nxt.line_sync = ls;
            nxt.frame_sync = fs;
            nxt.pixel_valid = pv;
        end
        run = 1'b0;
        step(20);
    endtask

    task automatic results;
        $display("compared %0d, fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (40000) @(posedge clk_in);
        fails++;
        $display("Error %0t: run did not finish", $time);
        results();
    end

    initial begin
        seed = 32'h3df70916;
        {rst_n_in, msel, fe, cfg18, run, ls, fs, pv} = 8'h0;
        {pd_n, sel} = {1'b1, EDGE_RISE};
        {dir, val, rdo, h1, h2, fl} = '0;
        nxt = '0;
        fails = 0;
        n_compared = 0;
        fe = 1'b1;
        step(6);
        `CHK(pix, WORD_W'(0))
        `CHK({strobe, g_oe_n, r_oe_n}, 7'h3f)
        rst_n_in = 1'b1;
        step(4);
        // filter on: pulses of 1 and 2 dropped, 3 and 4 pass late
        for (int l = 1; l < 5; l++) burst(l);
        // filter off, falling strobe edge
        fe = 1'b0;
        sel = ~EDGE_RISE;
        step(4);
        burst(1);
        burst(2);
        sel = EDGE_RISE;
        // 24-bit, then 18-bit by pin, then by configuration
        for (int k = 0; k < 3; k++) begin
            msel = (k == 1);
            cfg18 = (k == 2);
            dir = GPIO_N'($random(seed));
            val = GPIO_N'($random(seed));
            rdo = REG_OUT_N'($random(seed));
            step(10);
            m = msel || cfg18;
            `CHK(m18, m)
            `CHK(g_oe_n, m ? ~dir : 4'hf)
            `CHK(g_rd, m ? {pins.green[1:0], pins.red[1:0]} : 4'h0)
            `CHK(g_out & dir & {4{m}}, val & dir & {4{m}})
            `CHK({r_oe_n, r_out}, m ? {2'h0, rdo} : 4'hc)
            burst(0);
        end
        // power-down acts as reset, then normal operation returns
        pd_n = 1'b0;
        step(6);
        `CHK({pix, strobe, m18}, 33'h0)
        `CHK({g_oe_n, r_oe_n}, 6'h3f)
        pd_n = 1'b1;
        {h1, h2, fl} = '0;
        step(6);
        `CHK(m18, 1'b1)
        burst(3);
        `CHK(expq.size(), 0)
        results();
    end
endmodule
